// file: hw/dht_map.svh
// Register offsets, field positions, reset values and timing counts of the disk host task file.
`ifndef DHT_MAP_SVH
`define DHT_MAP_SVH
`define DHT_OFS_DATA 3'h0
`define DHT_OFS_ERROR 3'h1
`define DHT_OFS_COUNT 3'h2
`define DHT_OFS_SECTOR 3'h3
`define DHT_OFS_CYL_LOW 3'h4
`define DHT_OFS_CYL_HIGH 3'h5
`define DHT_OFS_DHS 3'h6
`define DHT_OFS_CMD 3'h7
`define DHT_OFS_HOST_CTRL 3'h6
`define DHT_OFS_ALT_STATUS 3'h6
`define DHT_DHS_DRIVE_BIT 4
`define DHT_DHS_ECC_BIT 7
`define DHT_CTRL_DMA_BIT 0
`define DHT_CTRL_IRQ_OFF_BIT 1
`define DHT_CTRL_SRST_BIT 2
`define DHT_ERR_NO_DATA_MARK 0
`define DHT_ERR_NO_CYL_ZERO 1
`define DHT_ERR_ABORTED 2
`define DHT_ERR_ID_NOT_FOUND 4
`define DHT_ERR_ECC 6
`define DHT_ERR_BAD_BLOCK 7
`define DHT_ERR_RSVD_MASK 8'hD7
`define DHT_RST_COUNT 8'h01
`define DHT_RST_SECTOR 8'h01
`define DHT_RST_CYL 8'h00
`define DHT_RST_DHS 8'h00
`define DHT_RST_CMD 8'h00
`define DHT_RST_CTRL 8'h00
`define DHT_STEP_LIMIT 12'h800
`endif

// file: hw/dht_pkg.sv
// Types shared by the disk host task file.
package dht_pkg;
  // Host bus request, one cycle per strobe.
  typedef struct packed {
    logic cs0;
    logic cs1;
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } dht_hostreq_type;
  // Events reported by the local sequencer, one-cycle pulses.
  typedef struct packed {
    logic stepPulse;
    logic trackZero;
    logic recalStart;
    logic badOpcode;
    logic sectorNotFound;
    logic idCrcError;
    logic noDataMark;
    logic syndromeNonZero;
    logic eccCorrected;
    logic badTrack;
    logic sectorDone;
    logic cmdDone;
    logic xferStart;
    logic xferEnd;
    logic [7:0] curSector;
    logic [15:0] curCylinder;
    logic posUpdate;
  } dht_seqev_type;
  // Controller phase.
  typedef enum logic [2:0] {
    DHT_IDLE = 3'b001,
    DHT_BUSY = 3'b010,
    DHT_XFER = 3'b100
  } dht_phase_type;
endpackage : dht_pkg

// file: hw/dht_task_file.sv
// Host register port of the disk controller: task file, host control, status and data port.
`timescale 1ns/10ps
`include "dht_map.svh"
module dht_task_file (
  input wire logic clk,
  input wire logic srst,
  input wire dht_pkg::dht_hostreq_type hostReq,
  input wire dht_pkg::dht_seqev_type seqEv,
  input wire logic wordMode,
  input wire logic dmaModeCfg,
  input wire logic dmaLocalEnable,
  input wire logic [5:0] driveStatusInputReg,
  input wire logic indexDrive0N,
  input wire logic indexDrive1N,
  input wire logic [15:0] xferWordIn,
  input wire logic xferWordValid,
  input wire logic irqRaise,
  input wire logic busyRelease,
  output logic [15:0] hostRdata,
  output logic ioCs16N,
  output logic ioChRdy,
  output logic hostIrqLineOut,
  output logic hostIrqLineOeN,
  output logic dmaReqOut,
  output logic dmaReqOeN,
  output logic commandStrobeN,
  output logic [7:0] commandOpcode,
  output logic [3:0] headSelect,
  output logic driveSelect,
  output logic eccSelect,
  output logic [1:0] sectorSizeCode,
  output logic [15:0] hostWordOut,
  output logic hostWordValid,
  output logic hostWordTaken
);
  // Raw index pins pass two flops before any logic reads them.
  logic [1:0] idx0Sync_q;
  logic [1:0] idx1Sync_q;
  // Task file registers.
  logic [7:0] count_q, count_d;
  logic [7:0] sector_q, sector_d;
  logic [7:0] cylLow_q, cylLow_d;
  logic [7:0] cylHigh_q, cylHigh_d;
  logic [7:0] dhs_q, dhs_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] error_q, error_d;
  // Status flags and bookkeeping.
  dht_pkg::dht_phase_type phase_q, phase_d;
  logic errFlag_q, errFlag_d;
  logic corrFlag_q, corrFlag_d;
  logic irqPend_q, irqPend_d;
  logic [11:0] stepCnt_q, stepCnt_d;
  logic recal_q, recal_d;
  logic [15:0] rdata_d;

  // Decoding of the host strobe.
  wire logic busy = (phase_q == dht_pkg::DHT_BUSY) || ctrl_q[`DHT_CTRL_SRST_BIT];
  wire logic wrTask = hostReq.wr && hostReq.cs0 && !busy;
  // Host control writes are never gated by busy, or a soft reset could never be left again.
  wire logic wrCtrl = hostReq.wr && hostReq.cs1 && hostReq.addr == `DHT_OFS_HOST_CTRL;
  wire logic rdTask = hostReq.rd && hostReq.cs0;
  wire logic wrReg7 = wrTask && hostReq.addr == `DHT_OFS_CMD;
  wire logic softReset = ctrl_q[`DHT_CTRL_SRST_BIT];
  wire logic rstAll = srst || softReset;
  wire logic drv = dhs_q[`DHT_DHS_DRIVE_BIT];
  wire logic ecc = dhs_q[`DHT_DHS_ECC_BIT];
  wire logic idxSel = drv ? idx1Sync_q[1] : idx0Sync_q[1];
  wire logic [2:0] drvStat = drv ? driveStatusInputReg[5:3] : driveStatusInputReg[2:0];
  wire logic driveFault = drvStat[1] || !drvStat[2];
  wire logic transfer_request_flag = (phase_q == dht_pkg::DHT_XFER);
  // Status byte: busy, ready, fault, seek, drq, corrected, index, error.
  wire logic [7:0] status = {busy, drvStat, transfer_request_flag, corrFlag_q && ecc, !idxSel, errFlag_q};
  wire logic dataAccess = hostReq.cs0 && hostReq.addr == `DHT_OFS_DATA && (hostReq.rd || hostReq.wr) && transfer_request_flag;
  wire logic statusRead = rdTask && hostReq.addr == `DHT_OFS_CMD;

  // Index pins pass through a two-stage synchroniser.
  // Only the second stage feeds logic; the first may still be settling from a metastable sample.
  always_ff @(posedge clk) begin
    idx0Sync_q <= {idx0Sync_q[0], indexDrive0N};
    idx1Sync_q <= {idx1Sync_q[0], indexDrive1N};
  end

  // Host control register; only a power-on reset clears it, so the host can release soft reset.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d = {5'h00, hostReq.wdata[2:0]};
    end
  end

  // Task file writes from the host and position updates from the sequencer.
  always_comb begin
    count_d = count_q;
    sector_d = sector_q;
    cylLow_d = cylLow_q;
    cylHigh_d = cylHigh_q;
    dhs_d = dhs_q;
    cmd_d = cmd_q;
    if (wrTask) begin
      case (hostReq.addr)
        `DHT_OFS_COUNT: begin
          count_d = hostReq.wdata[7:0];
        end
        `DHT_OFS_SECTOR: begin
          sector_d = hostReq.wdata[7:0];
        end
        `DHT_OFS_CYL_LOW: begin
          cylLow_d = hostReq.wdata[7:0];
        end
        `DHT_OFS_CYL_HIGH: begin
          cylHigh_d = hostReq.wdata[7:0];
        end
        `DHT_OFS_DHS: begin
          dhs_d = hostReq.wdata[7:0];
        end
        `DHT_OFS_CMD: begin
          cmd_d = hostReq.wdata[7:0];
        end
        default: begin
          cmd_d = cmd_q;
        end
      endcase
    end
    // Sequencer updates come after host writes, so the position of a running command wins.
    if (seqEv.sectorDone) begin
      count_d = count_q - 8'h01;
    end
    if (seqEv.posUpdate) begin
      sector_d = seqEv.curSector;
      cylLow_d = seqEv.curCylinder[7:0];
      cylHigh_d = seqEv.curCylinder[15:8];
    end
  end

  // Error register collects the failure causes of a command; a new command clears it.
  always_comb begin
    error_d = wrReg7 ? 8'h00 : error_q;
    recal_d = seqEv.recalStart ? 1'b1 : (seqEv.cmdDone ? 1'b0 : recal_q);
    // The step count starts again at a recalibration start and on every track-zero pulse.
    stepCnt_d = (seqEv.recalStart || seqEv.trackZero) ? 12'h000 : stepCnt_q;
    if (recal_q && seqEv.stepPulse && !seqEv.trackZero) begin
      stepCnt_d = stepCnt_q + 12'h001;
      if (stepCnt_q == `DHT_STEP_LIMIT - 12'h001) begin
        error_d[`DHT_ERR_NO_CYL_ZERO] = 1'b1;
      end
    end
    if (seqEv.badOpcode || (wrReg7 && driveFault)) begin
      error_d[`DHT_ERR_ABORTED] = 1'b1;
    end
    if (seqEv.sectorNotFound || seqEv.idCrcError) begin
      error_d[`DHT_ERR_ID_NOT_FOUND] = 1'b1;
    end
    if (seqEv.noDataMark) begin
      error_d[`DHT_ERR_NO_DATA_MARK] = 1'b1;
    end
    if (seqEv.syndromeNonZero) begin
      error_d[`DHT_ERR_ECC] = 1'b1;
    end
    if (seqEv.badTrack) begin
      error_d[`DHT_ERR_BAD_BLOCK] = 1'b1;
    end
    error_d = error_d & `DHT_ERR_RSVD_MASK;
  end

  // Phase machine: command write makes busy, data request clears busy, fatal errors end the command in the busy phase only.
  // A corrected syndrome is not fatal, so a multi-sector command keeps running after it.
  wire logic fatal = seqEv.badOpcode || seqEv.badTrack || (seqEv.syndromeNonZero && !seqEv.eccCorrected)
    || seqEv.sectorNotFound || seqEv.idCrcError || seqEv.noDataMark || (wrReg7 && driveFault);
  always_comb begin
    phase_d = phase_q;
    errFlag_d = wrReg7 ? 1'b0 : errFlag_q;
    corrFlag_d = wrReg7 ? 1'b0 : corrFlag_q;
    case (phase_q)
      dht_pkg::DHT_IDLE: begin
        if (wrReg7 && !driveFault) begin
          phase_d = dht_pkg::DHT_BUSY;
        end
      end
      dht_pkg::DHT_BUSY: begin
        if (fatal || seqEv.cmdDone || busyRelease) begin
          phase_d = dht_pkg::DHT_IDLE;
        end else if (seqEv.xferStart) begin
          phase_d = dht_pkg::DHT_XFER;
        end
      end
      dht_pkg::DHT_XFER: begin
        if (seqEv.xferEnd) begin
          phase_d = seqEv.cmdDone ? dht_pkg::DHT_IDLE : dht_pkg::DHT_BUSY;
        end
      end
      default: begin
        phase_d = dht_pkg::DHT_IDLE;
      end
    endcase
    if (fatal) begin
      errFlag_d = 1'b1;
    end
    if (seqEv.syndromeNonZero && seqEv.eccCorrected) begin
      corrFlag_d = 1'b1;
    end
  end

  // Interrupt pending: a raise in the same cycle as a status read wins.
  // The secondary status read leaves this flag alone, so polling it never loses an interrupt.
  always_comb begin
    irqPend_d = irqPend_q;
    if (statusRead && !busy) begin
      irqPend_d = 1'b0;
    end
    if (statusRead && busy) begin
      irqPend_d = 1'b0;
    end
    if (irqRaise || fatal || seqEv.cmdDone) begin
      irqPend_d = 1'b1;
    end
  end

  // Read data mux: busy gates status onto every read.
  always_comb begin
    rdata_d = 16'h0000;
    if (hostReq.cs1 && hostReq.addr == `DHT_OFS_ALT_STATUS) begin
      rdata_d = {8'h00, status};
    end else if (busy) begin
      rdata_d = {8'h00, status};
    end else begin
      case (hostReq.addr)
        `DHT_OFS_DATA: begin
          rdata_d = wordMode ? xferWordIn : {8'h00, xferWordIn[7:0]};
        end
        `DHT_OFS_ERROR: begin
          rdata_d = {8'h00, error_q};
        end
        `DHT_OFS_COUNT: begin
          rdata_d = {8'h00, count_q};
        end
        `DHT_OFS_SECTOR: begin
          rdata_d = {8'h00, sector_q};
        end
        `DHT_OFS_CYL_LOW: begin
          rdata_d = {8'h00, cylLow_q};
        end
        `DHT_OFS_CYL_HIGH: begin
          rdata_d = {8'h00, cylHigh_q};
        end
        `DHT_OFS_DHS: begin
          rdata_d = {8'h00, dhs_q};
        end
        default: begin
          rdata_d = {8'h00, status};
        end
      endcase
    end
  end

  // Control register and synchroniser survive soft reset; the error register survives every reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `DHT_RST_CTRL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // The error register has no reset at all, so the cause of a failure can be read after any reset.
  // It is unknown until the first command write clears it, which the host must allow for.
  always_ff @(posedge clk) begin
    error_q <= error_d;
  end

  // Task registers reset on power-on or soft reset.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      count_q <= `DHT_RST_COUNT;
      sector_q <= `DHT_RST_SECTOR;
      cylLow_q <= `DHT_RST_CYL;
      cylHigh_q <= `DHT_RST_CYL;
      dhs_q <= `DHT_RST_DHS;
      cmd_q <= `DHT_RST_CMD;
      phase_q <= dht_pkg::DHT_IDLE;
      errFlag_q <= 1'b0;
      corrFlag_q <= 1'b0;
      stepCnt_q <= 12'h000;
      recal_q <= 1'b0;
    end else begin
      count_q <= count_d;
      sector_q <= sector_d;
      cylLow_q <= cylLow_d;
      cylHigh_q <= cylHigh_d;
      dhs_q <= dhs_d;
      cmd_q <= cmd_d;
      phase_q <= phase_d;
      errFlag_q <= errFlag_d;
      corrFlag_q <= corrFlag_d;
      stepCnt_q <= stepCnt_d;
      recal_q <= recal_d;
    end
  end

  // Pending interrupt is left alone by tri-stating the line, only reset or status read clear it.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      irqPend_q <= 1'b0;
    end else begin
      irqPend_q <= irqPend_d;
    end
  end

  // Registered outputs toward the host and the local processor.
  // Fields taken from a register appear one edge after that register, since every output is a flop; commandOpcode takes cmd_d and so appears with cmd_q.
  // Both enables release their lines while power-on reset is held; then irq enable follows its bit, dma enable its bit gated by dmaModeCfg and dmaLocalEnable.
  always_ff @(posedge clk) begin
    if (srst) begin
      hostRdata <= 16'h0000;
      ioCs16N <= 1'b1;
      ioChRdy <= 1'b1;
      hostIrqLineOut <= 1'b0;
      hostIrqLineOeN <= 1'b1;
      dmaReqOut <= 1'b0;
      dmaReqOeN <= 1'b1;
      commandStrobeN <= 1'b1;
      commandOpcode <= 8'h00;
      headSelect <= 4'h0;
      driveSelect <= 1'b0;
      eccSelect <= 1'b0;
      sectorSizeCode <= 2'h0;
      hostWordOut <= 16'h0000;
      hostWordValid <= 1'b0;
      hostWordTaken <= 1'b0;
    end else begin
      hostRdata <= rdata_d;
      ioCs16N <= !(dataAccess && wordMode);
      ioChRdy <= !(dataAccess && wordMode && !xferWordValid && hostReq.rd);
      hostIrqLineOut <= irqPend_d;
      hostIrqLineOeN <= ctrl_q[`DHT_CTRL_IRQ_OFF_BIT];
      dmaReqOut <= transfer_request_flag;
      dmaReqOeN <= !(dmaModeCfg && dmaLocalEnable && ctrl_q[`DHT_CTRL_DMA_BIT]);
      commandStrobeN <= !wrReg7;
      commandOpcode <= cmd_d;
      headSelect <= dhs_q[3:0];
      driveSelect <= drv;
      eccSelect <= ecc;
      sectorSizeCode <= dhs_q[6:5];
      hostWordOut <= wordMode ? hostReq.wdata : {8'h00, hostReq.wdata[7:0]};
      hostWordValid <= dataAccess && hostReq.wr;
      hostWordTaken <= dataAccess && hostReq.rd;
    end
  end
endmodule : dht_task_file

// file: testbench/dht_host_model.sv
// Host processor model that issues single-cycle strobes on the task file bus.
`timescale 1ns/10ps
module dht_host_model (
  input wire logic clk,
  input wire logic [15:0] hostRdata,
  output dht_pkg::dht_hostreq_type hostReq
);
  // The bus idles deselected with no strobe.
  initial hostReq = '0;
  // One write; released data is inverted so a stale value is never mistaken for valid.
  task automatic wr(input logic sel1, input logic [2:0] a, input logic [15:0] d);
    if (sel1) d = d & 16'h0007;
    @(posedge clk);
    #1 hostReq = '{cs0: !sel1, cs1: sel1, addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
    @(posedge clk);
    #1 hostReq = {7'h00, ~d};
  endtask : wr
  // One read; data is taken once the taking edge has updated the output.
  task automatic rd(input logic sel1, input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 hostReq = '{cs0: !sel1, cs1: sel1, addr: a, rd: 1'b1, wr: 1'b0, wdata: 16'h0000};
    @(posedge clk);
    #1 d = hostRdata;
    hostReq = '0;
  endtask : rd
endmodule : dht_host_model

// file: testbench/dht_task_file_assertions.sv
// Port checker for the disk host task file.
`timescale 1ns/10ps
module dht_task_file_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire dht_pkg::dht_hostreq_type hostReq,
  input wire logic [5:0] driveStatusInputReg,
  input wire logic wordMode,
  input wire logic dmaModeCfg,
  input wire logic dmaLocalEnable,
  input wire logic [15:0] hostRdata,
  input wire logic ioCs16N,
  input wire logic ioChRdy,
  input wire logic hostIrqLineOeN,
  input wire logic dmaReqOeN,
  input wire logic commandStrobeN,
  input wire logic [7:0] commandOpcode,
  input wire logic [3:0] headSelect,
  input wire logic driveSelect,
  input wire logic eccSelect,
  input wire logic [1:0] sectorSizeCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Decoded host cycles, so each property reads as cause and effect.
  wire cmdWr = hostReq.wr && hostReq.cs0 && hostReq.addr == 3'h7;
  wire dhsWr = hostReq.wr && hostReq.cs0 && hostReq.addr == 3'h6;
  wire ctlWr = hostReq.wr && hostReq.cs1 && hostReq.addr == 3'h6;
  wire statRd = hostReq.rd && hostReq.cs0 && hostReq.addr == 3'h7;
  wire dataRd = hostReq.rd && hostReq.cs0 && hostReq.addr == 3'h0;
  wire [7:0] dhs = {eccSelect, sectorSizeCode, driveSelect, headSelect};
  a_strobe_cause: assert property ($fell(commandStrobeN) |-> $past(cmdWr))
    else $error("command strobe without a command write");
  a_strobe_width: assert property (!commandStrobeN |=> commandStrobeN)
    else $error("command strobe longer than one cycle");
  a_opcode_held: assert property (!commandStrobeN |-> commandOpcode == $past(hostReq.wdata[7:0]))
    else $error("opcode differs from written value");
  // Select fields and enables follow their register one edge later, hence the depth of two.
  a_dhs_source: assert property ($changed(dhs) |-> dhs == 8'h00 ||
    ($past(dhsWr, 2) && dhs == $past(hostReq.wdata[7:0], 2))) else $error("select fields changed without cause");
  a_irq_gate: assert property ($changed(hostIrqLineOeN) |->
    ($past(ctlWr, 2) && hostIrqLineOeN == $past(hostReq.wdata[1], 2)) || ($past(srst, 2) && !hostIrqLineOeN))
    else $error("irq enable wrong");
  a_dma_gate: assert property ($past(ctlWr, 2) |->
    dmaReqOeN == !($past(dmaModeCfg && dmaLocalEnable) && $past(hostReq.wdata[0], 2))) else $error("dma enable wrong");
  a_byte_quiet: assert property ($past(!wordMode) |-> ioCs16N && ioChRdy)
    else $error("byte mode drove word handshake");
  a_byte_upper: assert property ($past(dataRd && !wordMode) |-> hostRdata[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  a_drive_bits: assert property ($past(statRd) |->
    hostRdata[6:4] == $past(driveSelect ? driveStatusInputReg[5:3] : driveStatusInputReg[2:0]))
    else $error("status drive bits wrong");
  a_crc_clear: assert property ($past(statRd && !eccSelect) |-> !hostRdata[2])
    else $error("corrected bit set with crc");
  // Main scenarios that the bench is expected to reach.
  c_command: cover property (!commandStrobeN);
  c_status: cover property ($past(statRd));
  c_dma_on: cover property (!dmaReqOeN);
endmodule : dht_task_file_assertions

bind dht_task_file dht_task_file_assertions chk (.clk(clk), .srst(srst), .hostReq(hostReq),
  .driveStatusInputReg(driveStatusInputReg), .wordMode(wordMode), .dmaModeCfg(dmaModeCfg),
  .dmaLocalEnable(dmaLocalEnable), .hostRdata(hostRdata), .ioCs16N(ioCs16N), .ioChRdy(ioChRdy),
  .hostIrqLineOeN(hostIrqLineOeN), .dmaReqOeN(dmaReqOeN), .commandStrobeN(commandStrobeN),
  .commandOpcode(commandOpcode), .headSelect(headSelect), .driveSelect(driveSelect),
  .eccSelect(eccSelect), .sectorSizeCode(sectorSizeCode));

// file: testbench/disk_host_task_file_test.sv
// Self-checking bench for the disk host task file.
`timescale 1ns/10ps
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module disk_host_task_file_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  dht_pkg::dht_hostreq_type hostReq;
  dht_pkg::dht_seqev_type seqEv = '0;
  logic wordMode = 1'b0, dmaModeCfg = 1'b0, dmaLocalEnable = 1'b0, indexDrive0N = 1'b1, indexDrive1N = 1'b1;
  logic xferWordValid = 1'b0, irqRaise = 1'b0, busyRelease = 1'b0;
  logic [5:0] driveStatusInputReg = 6'h24;
  logic [15:0] xferWordIn = 16'h0000, hostRdata, hostWordOut, d, w;
  logic ioCs16N, ioChRdy, hostIrqLineOut, hostIrqLineOeN, dmaReqOut, dmaReqOeN, commandStrobeN;
  logic driveSelect, eccSelect, hostWordValid, hostWordTaken;
  logic [7:0] commandOpcode;
  logic [3:0] headSelect;
  logic [1:0] sectorSizeCode;
  logic [23:0] p;
  int mismatches = 0, total_checks = 0, i;
  // Sequencer event masks: no mark, sector missing, id crc, bad track, bad opcode, fatal ecc, corrected ecc.
  logic [38:0] evMask [7] = '{39'h1 << 32, 39'h1 << 34, 39'h1 << 33, 39'h1 << 29, 39'h1 << 35, 39'h1 << 31,
    39'h3 << 30};
  logic [7:0] errExp [7] = '{8'h01, 8'h10, 8'h10, 8'h80, 8'h04, 8'h40, 8'h40};
  always #5 clk = ~clk;
  dht_task_file uut (.clk(clk), .srst(srst), .hostReq(hostReq), .seqEv(seqEv), .wordMode(wordMode),
    .dmaModeCfg(dmaModeCfg), .dmaLocalEnable(dmaLocalEnable), .driveStatusInputReg(driveStatusInputReg),
    .indexDrive0N(indexDrive0N), .indexDrive1N(indexDrive1N), .xferWordIn(xferWordIn),
    .xferWordValid(xferWordValid), .irqRaise(irqRaise), .busyRelease(busyRelease), .hostRdata(hostRdata),
    .ioCs16N(ioCs16N), .ioChRdy(ioChRdy), .hostIrqLineOut(hostIrqLineOut), .hostIrqLineOeN(hostIrqLineOeN),
    .dmaReqOut(dmaReqOut), .dmaReqOeN(dmaReqOeN), .commandStrobeN(commandStrobeN),
    .commandOpcode(commandOpcode), .headSelect(headSelect), .driveSelect(driveSelect), .eccSelect(eccSelect),
    .sectorSizeCode(sectorSizeCode), .hostWordOut(hostWordOut), .hostWordValid(hostWordValid),
    .hostWordTaken(hostWordTaken));
  dht_host_model host (.clk(clk), .hostRdata(hostRdata), .hostReq(hostReq));
  // Expected drive status bits for the selected drive.
  function automatic logic [2:0] drvBits(input logic [5:0] r, input logic s);
    return s ? r[5:3] : r[2:0];
  endfunction : drvBits
  // Drives one sequencer event mask for a single cycle.
  task automatic pulse(input logic [38:0] m);
    @(posedge clk);
    #1 seqEv = m;
    @(posedge clk);
    #1 seqEv = '0;
  endtask : pulse
  // Ends the busy phase as the local processor would.
  task automatic release_busy();
    @(posedge clk);
    #1 busyRelease = 1'b1;
    @(posedge clk);
    #1 busyRelease = 1'b0;
  endtask : release_busy
  // Lets fields that follow a register by one more edge settle before they are compared.
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle
  // Issues a random command with drives ready, so it must start rather than abort.
  task automatic cmd();
    host.wr(1'b0, 3'h7, {8'h00, 8'($urandom)});
    `CK("strobe", 1'b0, commandStrobeN)
  endtask : cmd
  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // The whole run needs some 4400 cycles; this limit of 50000 cycles only catches a hang.
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hECD33D21));
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    host.rd(1'b0, 3'h2, d); `CK("count", 16'h0001, d)
    host.rd(1'b0, 3'h3, d); `CK("sector", 16'h0001, d)
    host.rd(1'b0, 3'h5, d); `CK("cyl high", 16'h0000, d)
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      w = {8'h00, 8'($urandom)};
      w[6:5] = i[1:0];
      host.wr(1'b0, 3'h6, w);
      settle();
      `CK("fields", w[7:0], {eccSelect, sectorSizeCode, driveSelect, headSelect})
      host.rd(1'b0, 3'h6, d); `CK("select read", w, d)
    end
    for (i = 0; i < 4; i++) begin
      driveStatusInputReg = 6'($urandom);
      indexDrive0N = !(i[1] && !i[0]);
      indexDrive1N = !(i[1] && i[0]);
      host.wr(1'b0, 3'h6, {11'h000, i[0], 4'h0});
      repeat (3) @(posedge clk);
      host.rd(1'b0, 3'h7, d);
      `CK("drive bits", drvBits(driveStatusInputReg, i[0]), d[6:4])
      `CK("index", i[1], d[1])
    end
    driveStatusInputReg = 6'h24;
    indexDrive1N = 1'b1;
    host.wr(1'b0, 3'h6, 16'h0080);
    $display("test status done");
    cmd();
    host.wr(1'b0, 3'h6, 16'h000F);
    host.rd(1'b0, 3'h6, d); `CK("busy read", 1'b1, d[7])
    pulse(39'h1 << 27);
    release_busy();
    host.rd(1'b0, 3'h6, d); `CK("ignored write", 16'h0080, d)
    host.wr(1'b1, 3'h6, 16'h0002);
    settle(); `CK("irq off", 1'b1, hostIrqLineOeN)
    `CK("still pending", 1'b1, hostIrqLineOut)
    host.rd(1'b0, 3'h7, d); `CK("irq cleared", 1'b0, hostIrqLineOut)
    host.wr(1'b1, 3'h6, 16'h0000);
    settle(); `CK("irq on", 1'b0, hostIrqLineOeN)
    $display("test command done");
    for (i = 0; i < 7; i++) begin
      cmd();
      pulse(evMask[i]);
      release_busy();
      host.rd(1'b0, 3'h1, d); `CK("error", {8'h00, errExp[i]}, d)
      host.rd(1'b0, 3'h7, d); `CK("status low", (i == 6) ? 3'b100 : 3'b001, d[2:0])
    end
    driveStatusInputReg = 6'h26;
    host.wr(1'b0, 3'h7, 16'h0020);
    host.rd(1'b0, 3'h1, d); `CK("fault abort", 16'h0004, d)
    driveStatusInputReg = 6'h24;
    cmd();
    pulse(39'h1 << 36);
    repeat (2048) pulse(39'h1 << 38);
    release_busy();
    host.rd(1'b0, 3'h1, d); `CK("no track zero", 16'h0002, d)
    $display("test errors done");
    host.wr(1'b0, 3'h6, 16'h0093);
    host.wr(1'b1, 3'h6, 16'h0004);
    host.rd(1'b0, 3'h7, d); `CK("soft busy", 1'b1, d[7])
    host.wr(1'b1, 3'h6, 16'h0000);
    host.rd(1'b0, 3'h6, d); `CK("soft cleared", 16'h0000, d)
    host.rd(1'b0, 3'h1, d); `CK("error kept", 16'h0002, d)
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    host.rd(1'b0, 3'h1, d); `CK("error kept", 16'h0002, d)
    $display("test resets done");
    cmd();
    p = 24'($urandom);
    pulse({14'h0008, p, 1'b1});
    release_busy();
    host.rd(1'b0, 3'h2, d); `CK("count step", 16'h0000, d)
    host.rd(1'b0, 3'h3, d); `CK("position sector", {8'h00, p[23:16]}, d)
    host.rd(1'b0, 3'h4, d); `CK("position cyl low", {8'h00, p[7:0]}, d)
    host.rd(1'b0, 3'h5, d); `CK("position cyl high", {8'h00, p[15:8]}, d)
    cmd();
    pulse(39'h1 << 26);
    host.rd(1'b0, 3'h7, d); `CK("data request", 2'b01, {d[7], d[3]})
    `CK("dma request", 1'b1, dmaReqOut)
    wordMode = 1'b1;
    w = 16'($urandom);
    host.wr(1'b0, 3'h0, w); `CK("word out", {1'b1, w}, {hostWordValid, hostWordOut})
    host.rd(1'b0, 3'h0, d); `CK("word wait", 2'b01, {ioChRdy, hostWordTaken})
    xferWordIn = 16'($urandom);
    xferWordValid = 1'b1;
    host.rd(1'b0, 3'h0, d); `CK("word in", {1'b0, xferWordIn}, {ioCs16N, d})
    wordMode = 1'b0;
    host.rd(1'b0, 3'h0, d); `CK("byte in", {2'b11, 8'h00, xferWordIn[7:0]}, {ioCs16N, ioChRdy, d})
    xferWordValid = 1'b0;
    pulse(39'h1 << 25);
    release_busy();
    $display("test data done");
    for (i = 0; i < 4; i++) begin
      {dmaModeCfg, dmaLocalEnable} = i[1:0];
      host.wr(1'b1, 3'h6, 16'h0001);
      settle(); `CK("dma enable", i != 3, dmaReqOeN)
    end
    host.wr(1'b1, 3'h6, 16'h0000);
    $display("test dma done");
    complete_run();
  end
endmodule : disk_host_task_file_test
